// ### hdl/stip_core.sv
/*
 * Interrupt, protection, reset-line and limitation PWM logic of the analog die.
 * Assumes asynchronous detector inputs and pins; registers over classic Wishbone.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Seven interrupt sources, each with flag and enable, combined on one output.
// - Every enable is writable by software individually.
// - Any reset clears all interrupt enables.
// - Undervoltage detector sets the undervoltage flag.
// - Undervoltage interrupt only while its enable is set.
// - Undervoltage turns off all high-side transistors and the high-side switch.
// - Halt mode disables undervoltage detection.
// - Overvoltage detector sets the overvoltage flag.
// - Overvoltage interrupt only while its enable is set.
// - Overvoltage turns off all high-side transistors and the high-side switch.
// - Halt mode disables overvoltage detection.
// - Temperature sensors above threshold set the overheat flag.
// - Overheat interrupt only while its enable is set.
// - Halt mode disables overheat detection.
// - Active-low open-drain interrupt signals errors and wake events.
// - Pull the shared reset line low while any internal reset source is active.
// - A low shared reset line forces the startup state; anyone may drive it.
// - Period input only sets PWM period; duty is generated internally.
// - High-side switch limits inrush with the period-derived PWM.
// - Half-bridge current limitation acts on low-side transistors only.
// - Enabled bus falling edge interrupts, and wakes in halt mode.
// - Overcurrent on any output interrupts when its enable is set.
// - Enabled wake event wakes controller and main regulator from halt.
module stip_core #(
	parameter int DUTY_W = stip_pkg::DUTY_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic supply_low_event_i,
	input wire logic supply_high_event_i,
	input wire logic overheat_event_i,
	input wire logic overcurrent_i,
	input wire logic hall_event_i,
	input wire logic wake_timer_i,
	input wire logic bus_line_i,
	input wire logic limit_pwm_period_in_i,
	input wire logic limit_sense_i,
	input wire logic int_reset_req_i,
	input wire logic rst_line_i,
	output logic rst_line_o,
	output logic rst_line_oe_n_o,
	output logic irq_line_o,
	output logic irq_line_oe_n_o,
	output logic high_side_switch_o,
	output logic [3:0] half_bridge_high_o,
	output logic [3:0] half_bridge_low_o,
	output logic wake_o,
	output logic main_regulator_on_o,
	output logic sys_rst_o
);
	localparam int NS = stip_pkg::SRC_N;
	localparam int NIN = 10;

	// Two-stage synchronisers for every asynchronous input
	logic [NIN-1:0] async_in;
	logic [NIN-1:0] meta_r;
	logic [NIN-1:0] sync_r;
	logic bus_prev_r;
	logic pwm_prev_r;
	assign async_in = {rst_line_i, limit_sense_i, limit_pwm_period_in_i, bus_line_i,
		wake_timer_i, hall_event_i, overcurrent_i, overheat_event_i,
		supply_high_event_i, supply_low_event_i};
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				meta_r[gi] <= async_in[gi];
				sync_r[gi] <= meta_r[gi];
			end
		end
	endgenerate
	logic s_lv, s_hv, s_ht, s_oc, s_hall, s_wt, s_bus, s_per, s_lim, s_rst;
	assign {s_rst, s_lim, s_per, s_bus, s_wt, s_hall, s_oc, s_ht, s_hv, s_lv} = sync_r;

	// Whole block reset: pin reset or shared line held low by anyone
	logic blk_rst;
	assign blk_rst = rst_i | ~s_rst;

	// Registers
	logic [NS-1:0] enable_r;
	logic [NS-1:0] flag_r;
	logic [31:0] ctrl_r;
	logic halt;
	assign halt = ctrl_r[stip_pkg::CTRL_HALT];

	// Wishbone decode; one-cycle ack, dropped the cycle after
	logic req;
	logic wr;
	logic [7:0] ofs;
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = cyc_i & stb_i & we_i & ack_o; // Commit on the edge the master sees ack
	assign ofs = adr_i[7:0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// Byte-lane write data merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Enable register, cleared on any reset
	logic [31:0] en_wr;
	assign en_wr = merge({25'h0, enable_r}, dat_i, sel_i);
	always_ff @(posedge clk_i) begin
		if (blk_rst) begin
			enable_r <= stip_pkg::ENABLE_RST;
		end else if (wr && ofs == stip_pkg::OFS_ENABLE) begin
			enable_r <= en_wr[NS-1:0];
		end
	end

	// Control register: halt, output requests, duty
	always_ff @(posedge clk_i) begin
		if (blk_rst) begin
			ctrl_r <= stip_pkg::CTRL_RST;
		end else if (wr && ofs == stip_pkg::OFS_CTRL) begin
			ctrl_r <= merge(ctrl_r, dat_i, sel_i);
		end else if (halt && wake_o) begin
			ctrl_r[stip_pkg::CTRL_HALT] <= 1'b0;
		end
	end

	// Event detection; halt disables supply and temperature detectors
	logic bus_fall;
	logic [NS-1:0] ev;
	assign bus_fall = bus_prev_r & ~s_bus;
	always_comb begin
		ev = '0;
		ev[stip_pkg::SRC_LV] = s_lv & ~halt;
		ev[stip_pkg::SRC_HV] = s_hv & ~halt;
		ev[stip_pkg::SRC_HT] = s_ht & ~halt;
		ev[stip_pkg::SRC_OC] = s_oc;
		ev[stip_pkg::SRC_BUS] = bus_fall;
		ev[stip_pkg::SRC_HALL] = s_hall;
		ev[stip_pkg::SRC_WAKE] = s_wt;
	end
	always_ff @(posedge clk_i) begin
		if (blk_rst) begin
			bus_prev_r <= 1'b1;
		end else begin
			bus_prev_r <= s_bus;
		end
	end

	// Sticky flags; write one clears, a new event wins over the clear
	generate
		for (gi = 0; gi < NS; gi++) begin : g_flag
			always_ff @(posedge clk_i) begin
				if (blk_rst) begin
					flag_r[gi] <= 1'b0;
				end else if (ev[gi]) begin
					flag_r[gi] <= 1'b1;
				end else if (wr && ofs == stip_pkg::OFS_FLAG && sel_i[0] && dat_i[gi]) begin
					flag_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Interrupt: level while any enabled flag stands; wake only while in halt with one standing
	logic [NS-1:0] pend;
	assign pend = flag_r & enable_r;
	always_ff @(posedge clk_i) begin
		if (blk_rst) begin
			irq_line_oe_n_o <= 1'b1;
			wake_o <= 1'b0;
			main_regulator_on_o <= 1'b1;
		end else begin
			irq_line_oe_n_o <= ~(|pend);
			wake_o <= halt & (|pend);
			main_regulator_on_o <= ~halt | (|pend);
		end
	end

	// Open drain only ever pulls low; the enable carries the level
	always_ff @(posedge clk_i) begin
		irq_line_o <= 1'b0;
	end

	// Shared reset line driver, stretched so the pull-down is seen
	logic [4:0] rst_cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || int_reset_req_i) begin
			rst_cnt_r <= 5'(stip_pkg::RST_STRETCH);
		end else if (rst_cnt_r != 5'h00) begin
			rst_cnt_r <= rst_cnt_r - 5'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		rst_line_oe_n_o <= ~(rst_i | int_reset_req_i | (rst_cnt_r != 5'h00));
		sys_rst_o <= blk_rst;
		rst_line_o <= 1'b0;
	end

	// Limitation PWM: period from input edges, duty from internal counter
	logic [DUTY_W-1:0] pwm_cnt_r;
	logic [DUTY_W-1:0] duty;
	logic per_rise;
	logic pwm_on;
	assign duty = ctrl_r[stip_pkg::CTRL_DUTY +: DUTY_W];
	assign per_rise = s_per & ~pwm_prev_r;
	assign pwm_on = pwm_cnt_r < duty;
	always_ff @(posedge clk_i) begin
		if (blk_rst) begin
			pwm_prev_r <= 1'b0;
			pwm_cnt_r <= '0;
		end else begin
			pwm_prev_r <= s_per;
			if (per_rise) begin
				pwm_cnt_r <= '0;
			end else if (pwm_cnt_r != {DUTY_W{1'b1}}) begin
				pwm_cnt_r <= pwm_cnt_r + 1'b1;
			end
		end
	end

	// Power outputs; supply faults cut only high-side stages
	logic supply_fault;
	assign supply_fault = flag_r[stip_pkg::SRC_LV] | flag_r[stip_pkg::SRC_HV];
	always_ff @(posedge clk_i) begin
		if (blk_rst) begin
			high_side_switch_o <= 1'b0;
			half_bridge_high_o <= 4'h0;
			half_bridge_low_o <= 4'h0;
		end else begin
			high_side_switch_o <= ctrl_r[stip_pkg::CTRL_HS_ON] & ~supply_fault
				& (pwm_on | ~s_lim);
			half_bridge_high_o <= supply_fault ? 4'h0
				: ctrl_r[stip_pkg::CTRL_HB_H +: 4];
			half_bridge_low_o <= ctrl_r[stip_pkg::CTRL_HB_L +: 4]
				& {4{pwm_on | ~s_lim}};
		end
	end

	// Read mux; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (req) begin
			case (ofs)
				stip_pkg::OFS_ENABLE: dat_o <= {25'h0, enable_r};
				stip_pkg::OFS_FLAG: dat_o <= {25'h0, flag_r};
				stip_pkg::OFS_CTRL: dat_o <= ctrl_r;
				stip_pkg::OFS_STATUS: dat_o <= {28'h0000000, s_ht, s_hv, s_lv, halt};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Assertions
	property p_en_clear;
		@(posedge clk_i) rst_i |=> enable_r == '0;
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enables not cleared");
	property p_irq_level;
		@(posedge clk_i) disable iff (blk_rst) (|(flag_r & enable_r)) |=> !irq_line_oe_n_o;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq not asserted");
	property p_irq_off;
		@(posedge clk_i) disable iff (blk_rst) ((flag_r & enable_r) == '0) |=> irq_line_oe_n_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without cause");
	property p_lv_set;
		@(posedge clk_i) disable iff (blk_rst) (s_lv && !halt) |=> flag_r[stip_pkg::SRC_LV];
	endproperty
	a_lv_set: assert property (p_lv_set) else $error("lv flag missing");
	property p_hv_set;
		@(posedge clk_i) disable iff (blk_rst) (s_hv && !halt) |=> flag_r[stip_pkg::SRC_HV];
	endproperty
	a_hv_set: assert property (p_hv_set) else $error("hv flag missing");
	property p_ht_set;
		@(posedge clk_i) disable iff (blk_rst) (s_ht && !halt) |=> flag_r[stip_pkg::SRC_HT];
	endproperty
	a_ht_set: assert property (p_ht_set) else $error("ht flag missing");
	property p_hs_cut;
		@(posedge clk_i) disable iff (blk_rst) supply_fault |=> !high_side_switch_o
			&& half_bridge_high_o == 4'h0;
	endproperty
	a_hs_cut: assert property (p_hs_cut) else $error("high side not cut");
	property p_sync;
		@(posedge clk_i) disable iff (rst_i) $rose(supply_low_event_i) ##1 supply_low_event_i
			|-> ##1 sync_r[0];
	endproperty
	a_sync: assert property (p_sync) else $error("sync latency wrong");
	property p_rst_line;
		@(posedge clk_i) int_reset_req_i |=> !rst_line_oe_n_o;
	endproperty
	a_rst_line: assert property (p_rst_line) else $error("reset line not pulled");
	c_lv: cover property (@(posedge clk_i) flag_r[stip_pkg::SRC_LV] && !irq_line_oe_n_o);
	c_bus_wake: cover property (@(posedge clk_i) halt && bus_fall);
	c_pwm: cover property (@(posedge clk_i) per_rise && s_lim);
	property p_wake;
		@(posedge clk_i) disable iff (blk_rst) (halt && (|pend)) |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not raised");
	property p_halt_mute;
		@(posedge clk_i) disable iff (blk_rst)
			(halt && !flag_r[stip_pkg::SRC_LV] && !flag_r[stip_pkg::SRC_HV]
			&& !flag_r[stip_pkg::SRC_HT]) |=> (!flag_r[stip_pkg::SRC_LV]
			&& !flag_r[stip_pkg::SRC_HV] && !flag_r[stip_pkg::SRC_HT]);
	endproperty
	a_halt_mute: assert property (p_halt_mute) else $error("flag set in halt");
	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_oc_set;
		@(posedge clk_i) disable iff (blk_rst) s_oc |=> flag_r[stip_pkg::SRC_OC];
	endproperty
	a_oc_set: assert property (p_oc_set) else $error("oc flag missing");
	property p_bus_set;
		@(posedge clk_i) disable iff (blk_rst) bus_fall |=> flag_r[stip_pkg::SRC_BUS];
	endproperty
	a_bus_set: assert property (p_bus_set) else $error("bus edge flag missing");
	c_wake: cover property (@(posedge clk_i) wake_o && main_regulator_on_o);
endmodule // stip_core
`default_nettype wire

// ### hdl/stip_pkg.sv
/*
 * Constants for the supply/temperature interrupt and protection block.
 * Assumes a 32-bit classic Wishbone slave with byte addressing.
 */
package stip_pkg;
	// Interrupt source bit positions in flag, enable and detector vectors
	localparam int SRC_N = 7;
	localparam int SRC_OC = 1;
	localparam int SRC_HV = 2;
	localparam int SRC_LV = 3;
	localparam int SRC_HT = 4;
	localparam int SRC_BUS = 5;
	localparam int SRC_HALL = 6;
	localparam int SRC_WAKE = 0;
	// Register byte offsets
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_FLAG = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	// Control register fields
	localparam int CTRL_HALT = 0;
	localparam int CTRL_HS_ON = 1;
	localparam int CTRL_HB_H = 2;
	localparam int CTRL_HB_L = 6;
	localparam int CTRL_DUTY = 16;
	localparam int DUTY_W = 8;
	// Reset values
	localparam logic [6:0] ENABLE_RST = 7'h00;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Reset line stretch in cycles
	localparam int RST_STRETCH = 16;
endpackage : stip_pkg

// ### verification/stip_mcu_model.sv
/* Controller side of the block: open-drain reset and interrupt wires with
   pull-ups, and the limitation period source. Assumes enables low = pulling. */
`timescale 1ns/1ps
`default_nettype none
module stip_mcu_model #(
	parameter int HALF = 4000
) (
	input wire logic clk_i,
	input wire logic rst_oe_n_i,
	input wire logic irq_oe_n_i,
	input wire logic pull_rst_i,
	output logic rst_line_o,
	output logic irq_line_o,
	output logic period_o
);
	int cnt = 0;
	logic per = 1'b0;
	// Pull-up wins unless a party pulls low; anyone may pull reset
	assign rst_line_o = !(!rst_oe_n_i || pull_rst_i);
	assign irq_line_o = irq_oe_n_i;
	assign period_o = per;
	// 8000-cycle period, about 15.6 kHz, inside the allowed band
	always @(posedge clk_i) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1)
			per <= ~per;
	end
endmodule // stip_mcu_model
`default_nettype wire

// ### verification/supply_temp_irq_protect_tb.sv
/* Self-checking bench for the protection block: bus tasks, event scans,
   halt mode and reset sources. Assumes the controller model beside it. */
`timescale 1ns/1ps
`default_nettype none
module supply_temp_irq_protect_tb;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ireq = 0, pull = 0;
	logic lim = 0, bl = 1, wk, wake, mro;
	logic [31:0] adr = 0, wd = 0, rd, dat_o, e;
	logic [3:0] sel = 0, hbh, hbl;
	logic [5:0] ev = 0;
	logic ack, roe_n, ioe_n, rline, iline, per, hs, srst;
	int n_mismatch = 0, total_checks = 0, seed = 27, k;
	int pos [6] = '{stip_pkg::SRC_LV, stip_pkg::SRC_HV, stip_pkg::SRC_HT, stip_pkg::SRC_OC,
		stip_pkg::SRC_HALL, stip_pkg::SRC_WAKE};
	stip_core i_stip_core (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wd),
		.dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
		.supply_low_event_i(ev[0]), .supply_high_event_i(ev[1]), .overheat_event_i(ev[2]),
		.overcurrent_i(ev[3]), .hall_event_i(ev[4]), .wake_timer_i(ev[5]), .bus_line_i(bl),
		.limit_pwm_period_in_i(per), .limit_sense_i(lim), .int_reset_req_i(ireq),
		.rst_line_i(rline), .rst_line_o(), .rst_line_oe_n_o(roe_n), .irq_line_o(),
		.irq_line_oe_n_o(ioe_n), .high_side_switch_o(hs), .half_bridge_high_o(hbh),
		.half_bridge_low_o(hbl), .wake_o(wake), .main_regulator_on_o(mro), .sys_rst_o(srst));
	stip_mcu_model i_stip_mcu_model (.clk_i(clk_i), .rst_oe_n_i(roe_n),
		.irq_oe_n_i(ioe_n), .pull_rst_i(pull), .rst_line_o(rline), .irq_line_o(iline),
		.period_o(per));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic results;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Expected high-side gates: cut by a supply flag, else as programmed
	function automatic logic [31:0] hb_exp(input logic cut, input logic [31:0] c);
		return cut ? 32'h0 : {28'h0, c[5:2]};
	endfunction
	// Classic cycle: request stands until ack is sampled high at a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		adr <= {24'h00, a};
		we <= w;
		wd <= d;
		sel <= 4'hf;
		cyc <= 1'b1;
		stb <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1) begin
			n_mismatch++;
			results();
		end
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// Block reset lags its cause by the synchroniser, so let it start, then end
	task automatic wait_up;
		int i;
		repeat (4) @(posedge clk_i);
		for (i = 0; i < 60 && srst !== 1'b0; i++)
			@(negedge clk_i);
		if (i >= 60) begin
			n_mismatch++;
			results();
		end
	endtask
	// Period level from the model; bounded so a stuck source ends the run
	task automatic wait_per(input logic v);
		int i;
		for (i = 0; i < 9000 && per !== v; i++)
			@(posedge clk_i);
		if (i >= 9000) begin
			n_mismatch++;
			results();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("reset pull", 0, roe_n);
		@(posedge clk_i);
		rst_i <= 1'b0;
		wait_up();
		bus(stip_pkg::OFS_ENABLE, 0, 0);
		chk("enable after reset", {25'h0, stip_pkg::ENABLE_RST}, rd);
		repeat (4) begin
			e = $random(seed);
			bus(stip_pkg::OFS_ENABLE, 1, e);
			bus(stip_pkg::OFS_ENABLE, 0, 0);
			chk("enable", {25'h0, e[6:0]}, rd);
		end
		bus(8'h10, 1, 32'hffff_ffff);
		bus(8'h10, 0, 0);
		chk("unmapped", 0, rd);
		bus(stip_pkg::OFS_ENABLE, 1, 0);
		bus(stip_pkg::OFS_CTRL, 1, 32'h0000_02be);
		for (k = 0; k < 6; k++) begin
			ev[k] <= 1'b1;
			repeat (6) @(negedge clk_i);
			bus(stip_pkg::OFS_FLAG, 0, 0);
			chk("flag", 32'h1 << pos[k], rd);
			chk("irq masked", 1, ioe_n);
			chk("high sides", hb_exp(k < 2, 32'h2be), hbh);
			chk("hs switch", k >= 2, hs);
			chk("low sides", 32'ha, hbl);
			bus(stip_pkg::OFS_ENABLE, 1, 32'h1 << pos[k]);
			repeat (3) @(negedge clk_i);
			chk("irq wire", 0, iline);
			@(posedge clk_i);
			ev[k] <= 1'b0;
			repeat (4) @(negedge clk_i);
			bus(stip_pkg::OFS_FLAG, 1, 32'h1 << pos[k]);
			repeat (3) @(negedge clk_i);
			chk("irq released", 1, ioe_n);
			chk("high sides back", 32'hf, hbh);
			bus(stip_pkg::OFS_ENABLE, 1, 0);
		end
		// Limit active: 16-cycle duty from each period rise gates HS and low sides
		bus(stip_pkg::OFS_CTRL, 1, 32'h0010_02be);
		lim <= 1'b1;
		wait_per(1'b0);
		wait_per(1'b1);
		repeat (8) @(negedge clk_i);
		chk("pwm high side", 1, hs);
		chk("pwm low sides", 32'ha, hbl);
		repeat (30) @(negedge clk_i);
		chk("pwm high side off", 0, hs);
		chk("pwm low sides off", 0, hbl);
		chk("pwm high sides kept", 32'hf, hbh);
		@(posedge clk_i);
		lim <= 1'b0;
		bus(stip_pkg::OFS_CTRL, 1, 32'h0000_02bf);
		ev <= 6'h07;
		repeat (8) @(negedge clk_i);
		bus(stip_pkg::OFS_FLAG, 0, 0);
		chk("halt flags", 0, rd);
		bus(stip_pkg::OFS_STATUS, 0, 0);
		chk("halt status", 32'hf, rd);
		chk("regulator in halt", 0, mro);
		// Enabled bus falling edge must wake from halt
		ev <= 6'h00;
		bus(stip_pkg::OFS_ENABLE, 1, 32'h1 << stip_pkg::SRC_BUS);
		bl <= 1'b0;
		wk = 1'b0;
		repeat (12) begin
			@(posedge clk_i);
			if (wake === 1'b1)
				wk = 1'b1;
		end
		chk("wake", 1, wk);
		chk("regulator woken", 1, mro);
		chk("irq on bus edge", 0, ioe_n);
		bus(stip_pkg::OFS_STATUS, 0, 0);
		chk("halt left", 0, rd);
		bus(stip_pkg::OFS_FLAG, 0, 0);
		chk("bus flag", 32'h1 << stip_pkg::SRC_BUS, rd);
		bl <= 1'b1;
		ireq <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk("internal reset pull", 0, roe_n);
		@(posedge clk_i);
		ireq <= 1'b0;
		wait_up();
		bus(stip_pkg::OFS_ENABLE, 1, 32'h7f);
		bus(stip_pkg::OFS_ENABLE, 0, 0);
		chk("enable before line reset", 32'h7f, rd);
		pull <= 1'b1;
		repeat (4) @(negedge clk_i);
		chk("line reset", 1, srst);
		@(posedge clk_i);
		pull <= 1'b0;
		wait_up();
		bus(stip_pkg::OFS_ENABLE, 0, 0);
		chk("enable after line reset", 0, rd);
		results();
	end
endmodule // supply_temp_irq_protect_tb
`default_nettype wire
